// ==== hdl/ihp_host_port.sv ====
// indirect asynchronous host bus port: fifo and top level
// assumes the host bus pins are asynchronous to sys_clk and held across several clocks,
// and an internal register core that takes writes from the fifo and answers reads in one cycle
//
// Function
// - phase-select low is a data access, high a command access
// - 16-bit command: address 10:2 from lines 10:2, enables from 15:12
// - 8-bit address sent as two command writes, low byte then bits 10:8
// - data uses sixteen lines in 16-bit mode, low eight in 8-bit mode
// - 16-bit bus accepts byte and word transfers, 8-bit bus bytes only
// - bus cycles answered only while chip select is low; no address decode
// - interrupt output driven low while an interrupt is pending
// - read data held valid on the bus until the read strobe rises
// - write data or command captured at write strobe falling edge with chip select
// - endian strap sampled a few clocks after reset release: high little, low big
// - frame pointer bit 11 selects endianness and overrides the strap
// - command read returns last address and enables in 16-bit mode only
// - single and burst transfers work without an external address latch
`timescale 1ns/1ps
`default_nettype none

module ihp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : ihp_fifo

module ihp_host_port import ihp_pkg::*; #(
  parameter logic [8:0] FRAME_PTR = FRAME_PTR_ADDR,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host bus pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic phase_select,
  input wire logic [15:0] shared_data_bus_in,
  output logic [15:0] shared_data_bus_out,
  output logic shared_data_bus_oe,
  output logic interrupt_out_n,
  // straps and configuration
  input wire logic endian_strap_pin,
  input wire logic bus_width_16,
  // register core write side
  output logic core_wr_valid,
  input wire logic core_wr_ready,
  output ihp_req_t core_wr_req,
  // register core read side
  output logic core_rd_req,
  output ihp_cmd_t core_rd_cmd,
  input wire logic [31:0] core_rd_data,
  // interrupt and status
  input wire logic irq_pending,
  output logic endian_big,
  output ihp_cmd_t cmd_latched,
  output logic wr_overflow,
  input wire logic wr_overflow_clr
);

  // pins pass two flip-flops before any logic looks at them
  logic [4:0] ctl_meta;
  logic [4:0] ctl_sync;
  logic [15:0] bus_meta;
  logic [15:0] bus_sync;
  logic wr_prev;
  logic rd_prev;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic cmd_s;
  logic strap_s;
  logic wr_fall;
  logic rd_fall;
  logic cmd_second;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_empty_n;
  ihp_req_t next_req;
  ihp_rd_state_t rd_state;
  logic [15:0] rd_hold;
  logic [15:0] half;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_meta <= 5'h1F;
      ctl_sync <= 5'h1F;
      bus_meta <= 16'h0000;
      bus_sync <= 16'h0000;
    end else begin
      ctl_meta <= {endian_strap_pin, phase_select, write_strobe_n, read_strobe_n, chip_select_n};
      ctl_sync <= ctl_meta;
      bus_meta <= shared_data_bus_in;
      bus_sync <= bus_meta;
    end
  end

  assign cs_s = !ctl_sync[0];
  assign rd_s = !ctl_sync[1];
  assign wr_s = !ctl_sync[2];
  assign cmd_s = ctl_sync[3];
  assign strap_s = ctl_sync[4];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= wr_s;
      rd_prev <= rd_s;
    end
  end

  // strobes count only while chip select is low
  assign wr_fall = wr_s && !wr_prev && cs_s;
  assign rd_fall = rd_s && !rd_prev && cs_s;

  // command latch, held until the next command write so bursts hit one register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_latched <= '0;
      cmd_second <= 1'b0;
    end else if (wr_fall && cmd_s) begin
      if (bus_width_16) begin
        cmd_latched.addr <= bus_sync[CMD_ADDR_MSB:CMD_ADDR_LSB];
        cmd_latched.lanes <= bus_sync[CMD_LANE_MSB:CMD_LANE_LSB];
        cmd_latched.byte_sel <= 2'h0;
        cmd_second <= 1'b0;
      end else if (!cmd_second) begin
        cmd_latched.addr[5:0] <= bus_sync[7:2];
        cmd_latched.byte_sel <= bus_sync[1:0];
        cmd_latched.lanes <= ihp_onehot(bus_sync[1:0]);
        cmd_second <= 1'b1;
      end else begin
        cmd_latched.addr[8:6] <= bus_sync[CMD8_HI_MSB:0];
        cmd_second <= 1'b0;
      end
    end
  end

  // data write request; 8-bit data is replicated so the lane enable picks the byte
  always_comb begin
    next_req.addr = cmd_latched.addr;
    next_req.lanes = cmd_latched.lanes;
    if (bus_width_16) begin
      next_req.data = {2{ihp_swap16(bus_sync, endian_big)}};
    end else begin
      next_req.data = {4{bus_sync[7:0]}};
    end
  end

  // the async host cannot be stalled, so a write into a full fifo is dropped and flagged
  assign fifo_in_valid = wr_fall && !cmd_s;

  ihp_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(next_req),
    .out_valid(fifo_empty_n),
    .out_ready(core_wr_ready),
    .out_data(core_wr_req)
  );

  assign core_wr_valid = fifo_empty_n;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_overflow <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      wr_overflow <= 1'b1;
    end else if (wr_overflow_clr) begin
      wr_overflow <= 1'b0;
    end
  end

  // endian: strap caught after release, a frame pointer write overrides it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      endian_big <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == STRAP_DELAY) begin
        endian_big <= !strap_s;
        strap_done <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end else if (fifo_in_valid && fifo_in_ready && next_req.addr == FRAME_PTR && next_req.lanes[1]) begin
      endian_big <= next_req.data[ENDIAN_BIT];
    end
  end

  // reads wait for pending writes so they see the newest register value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_state <= IHP_IDLE;
      rd_hold <= 16'h0000;
      core_rd_req <= 1'b0;
      core_rd_cmd <= '0;
    end else begin
      core_rd_req <= 1'b0;
      case (rd_state)
        IHP_IDLE: begin
          if (rd_fall && cmd_s) begin
            rd_hold <= bus_width_16 ? {cmd_latched.lanes, 1'b0, cmd_latched.addr, 2'h0} : 16'h0000;
            rd_state <= IHP_HOLD;
          end else if (rd_fall) begin
            rd_state <= IHP_DRAIN;
          end
        end
        IHP_DRAIN: begin
          if (!rd_s) begin
            rd_state <= IHP_IDLE;
          end else if (!fifo_empty_n) begin
            core_rd_req <= 1'b1;
            core_rd_cmd <= cmd_latched;
            rd_state <= IHP_FETCH;
          end
        end
        IHP_FETCH: begin
          rd_hold <= half;
          rd_state <= IHP_HOLD;
        end
        IHP_HOLD: begin
          // level, not edge: a strobe released during the fetch must not strand the state
          if (!rd_s) begin
            rd_state <= IHP_IDLE;
          end
        end
        default: begin
          rd_state <= IHP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    if (bus_width_16) begin
      half = ihp_swap16((core_rd_cmd.lanes[1:0] != 2'h0) ? core_rd_data[15:0] : core_rd_data[31:16], endian_big);
    end else begin
      half = {8'h00, core_rd_data[8*core_rd_cmd.byte_sel +: 8]};
    end
  end

  // bus driven from the held register until the read strobe rises
  assign shared_data_bus_out = rd_hold;
  assign shared_data_bus_oe = cs_s && rd_s && (rd_state == IHP_HOLD);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !irq_pending;
    end
  end

endmodule : ihp_host_port

`default_nettype wire

// ==== hdl/ihp_pkg.sv ====
// shared constants and types of the indirect host bus port
// assumes one 10 MHz system clock and an asynchronous active high reset
package ihp_pkg;

  localparam int CLK_HZ = 10000000;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 4;

  // shared data bus field layout in a 16-bit command cycle
  localparam int CMD_ADDR_LSB = 2;
  localparam int CMD_ADDR_MSB = 10;
  localparam int CMD_LANE_LSB = 12;
  localparam int CMD_LANE_MSB = 15;
  // 8-bit second command write carries address bits 10:8 on lines 2:0
  localparam int CMD8_HI_MSB = 2;

  // word index of the receive frame pointer register and its endian bit
  localparam logic [8:0] FRAME_PTR_ADDR = 9'h000;
  localparam int ENDIAN_BIT = 11;

  localparam logic [1:0] STRAP_DELAY = 2'h2;

  typedef struct packed {
    logic [8:0] addr;
    logic [3:0] lanes;
    logic [1:0] byte_sel;
  } ihp_cmd_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [3:0] lanes;
    logic [31:0] data;
  } ihp_req_t;

  localparam int REQ_W = $bits(ihp_req_t);

  typedef enum logic [1:0] {
    IHP_IDLE = 2'h0,
    IHP_DRAIN = 2'h1,
    IHP_FETCH = 2'h3,
    IHP_HOLD = 2'h2
  } ihp_rd_state_t;

  function automatic logic [15:0] ihp_swap16(input logic [15:0] w, input logic big);
    ihp_swap16 = big ? {w[7:0], w[15:8]} : w;
  endfunction : ihp_swap16

  function automatic logic [3:0] ihp_onehot(input logic [1:0] sel);
    ihp_onehot = 4'h1 << sel;
  endfunction : ihp_onehot

endpackage : ihp_pkg

// ==== sim/ihp_host_model.sv ====
// host processor model driving the port's pins
// assumes strobes held long enough for the pin sync
`timescale 1ns/1ps
`default_nettype none
module ihp_host_model (
  // clock
  input wire logic sys_clk,
  // host pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic phase_select,
  output logic [15:0] host_data_lines,
  output logic host_oe,
  // resolved bus
  input wire logic [15:0] shared_data_bus
);
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    phase_select = 1'b0;
    host_data_lines = 16'h0000;
    host_oe = 1'b0;
  end
  // one strobe cycle; pins move only at falling edges
  task automatic acc(input logic wr, input logic ph, input logic cs_n, input logic [15:0] v,
                     output logic [15:0] r);
    @(negedge sys_clk);
    chip_select_n = cs_n;
    phase_select = ph;
    host_data_lines = v;
    host_oe = wr;
    repeat (3) @(negedge sys_clk);
    if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    // long strobe covers sync delay and the fetch
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    r = shared_data_bus;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chip_select_n = 1'b1;
    host_oe = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : acc
endmodule : ihp_host_model
`default_nettype wire

// ==== sim/ihp_host_port_asserts.sv ====
// checker on the host port pins and core side
// assumes one clock domain and the 2-flop pin sync of the port
`timescale 1ns/1ps
`default_nettype none
module ihp_host_port_asserts import ihp_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic phase_select,
  input wire logic [15:0] shared_data_bus_out,
  input wire logic shared_data_bus_oe,
  input wire logic interrupt_out_n,
  // core side and status
  input wire logic core_wr_valid,
  input wire logic core_wr_ready,
  input wire ihp_req_t core_wr_req,
  input wire logic core_rd_req,
  input wire logic irq_pending,
  input wire ihp_cmd_t cmd_latched,
  input wire logic wr_overflow,
  input wire logic wr_overflow_clr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_intr_follow: assert property (!$past(rst) |-> interrupt_out_n == !$past(irq_pending))
    else $error("interrupt output not following request");
  chk_oe_cause: assert property ($rose(shared_data_bus_oe) |->
    $past(chip_select_n, 3) == 1'b0 && $past(read_strobe_n, 3) == 1'b0)
    else $error("bus driven without selected read");
  chk_oe_idle: assert property (read_strobe_n [*4] |-> !shared_data_bus_oe)
    else $error("bus driven after read strobe release");
  chk_out_hold: assert property (shared_data_bus_oe && $past(shared_data_bus_oe) |->
    $stable(shared_data_bus_out))
    else $error("read data moved while driven");
  chk_rd_pulse: assert property (core_rd_req |=> !core_rd_req)
    else $error("read request longer than one cycle");
  chk_cs_quiet: assert property (chip_select_n [*4] |-> !core_rd_req && !shared_data_bus_oe)
    else $error("activity while deselected");
  chk_wr_hold: assert property (core_wr_valid && !core_wr_ready |=>
    core_wr_valid && $stable(core_wr_req))
    else $error("write head lost under stall");
  chk_cmd_cause: assert property ($changed(cmd_latched) |->
    $past(write_strobe_n, 3) == 1'b0 && $past(phase_select, 3) == 1'b1)
    else $error("command changed without command write");
  chk_ovf_sticky: assert property (wr_overflow && !wr_overflow_clr |=> wr_overflow)
    else $error("overflow flag dropped");
endmodule : ihp_host_port_asserts
bind ihp_host_port ihp_host_port_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .phase_select(phase_select), .shared_data_bus_out(shared_data_bus_out),
  .shared_data_bus_oe(shared_data_bus_oe), .interrupt_out_n(interrupt_out_n),
  .core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready), .core_wr_req(core_wr_req),
  .core_rd_req(core_rd_req), .irq_pending(irq_pending), .cmd_latched(cmd_latched),
  .wr_overflow(wr_overflow), .wr_overflow_clr(wr_overflow_clr));
`default_nettype wire

// ==== sim/test_indirect_async_host_bus_port.sv ====
// bench for the indirect host bus port
// assumes the host model on the pins and a fixed-word core stub
`timescale 1ns/1ps
`default_nettype none
module test_indirect_async_host_bus_port import ihp_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic w16 = 1'b1;
  logic wr_rdy = 1'b1;
  logic irq = 1'b0;
  logic clr = 1'b0;
  logic [15:0] pat = 16'h5A5A;
  logic [15:0] r, h_d, bus, bus_out;
  logic [31:0] rd_data;
  logic cs_n, rd_n, wr_n, ph, h_oe, oe, wr_v, rd_req, big, ovf, intr_n;
  ihp_req_t wreq;
  ihp_cmd_t rcmd, cmd;
  ihp_req_t wq[$];
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  ihp_host_model h (.sys_clk(sys_clk), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .phase_select(ph), .host_data_lines(h_d), .host_oe(h_oe),
    .shared_data_bus(bus));
  ihp_host_port dut (.sys_clk(sys_clk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .phase_select(ph), .shared_data_bus_in(bus),
    .shared_data_bus_out(bus_out), .shared_data_bus_oe(oe), .interrupt_out_n(intr_n),
    .endian_strap_pin(strap), .bus_width_16(w16), .core_wr_valid(wr_v), .core_wr_ready(wr_rdy),
    .core_wr_req(wreq), .core_rd_req(rd_req), .core_rd_cmd(rcmd), .core_rd_data(rd_data),
    .irq_pending(irq), .endian_big(big), .cmd_latched(cmd), .wr_overflow(ovf),
    .wr_overflow_clr(clr));
  always #50 sys_clk = ~sys_clk;
  // core stub answers only while its read request stands, so a mistimed fetch reads zero
  assign rd_data = rd_req ? 32'hCAFE1357 : 32'h00000000;
  // released bus shows a moving pattern, not the last value
  always @(posedge sys_clk) pat <= ~pat;
  assign bus = h_oe ? h_d : (oe ? bus_out : pat);
  always @(posedge sys_clk) if (wr_v && wr_rdy) wq.push_back(wreq);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic t_cmd16();
    h.acc(1, 1, 0, 16'h30D0, r);
    chk(32'(cmd.addr), 32'h034);
    chk(32'(cmd.lanes), 32'h3);
    h.acc(0, 1, 0, 16'h0000, r);
    chk(32'(r), 32'h30D0);
  endtask : t_cmd16
  task automatic t_data16();
    wq.delete();
    h.acc(1, 0, 0, 16'h1234, r);
    chk(32'(wq.size()), 32'h1);
    chk(wq[0].data, 32'h12341234);
    h.acc(0, 0, 0, 16'h0000, r);
    chk(32'(r), 32'h1357);
    h.acc(0, 0, 0, 16'h0000, r);
    chk(32'(r), 32'h1357);
    chk(32'(rcmd.addr), 32'h034);
  endtask : t_data16
  task automatic t_cs();
    h.acc(1, 1, 1, 16'hF0FC, r);
    chk(32'(cmd.addr), 32'h034);
  endtask : t_cs
  task automatic t_fill();
    @(negedge sys_clk) wr_rdy = 1'b0;
    wq.delete();
    for (int i = 1; i <= 5; i++) h.acc(1, 0, 0, 16'(i), r);
    chk(32'(ovf), 32'h1);
    chk(32'(wq.size()), 32'h0);
    // core stalls long, then drains everything
    @(negedge sys_clk) wr_rdy = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(32'(wq.size()), 32'h4);
    chk(wq[3].data, 32'h00040004);
    chk(32'(wr_v), 32'h0);
    clr = 1'b1;
    @(negedge sys_clk) clr = 1'b0;
    chk(32'(ovf), 32'h0);
  endtask : t_fill
  task automatic t_endian();
    h.acc(1, 1, 0, 16'h3000, r);
    h.acc(1, 0, 0, 16'h0800, r);
    chk(32'(big), 32'h1);
    h.acc(1, 1, 0, 16'h30D0, r);
    h.acc(0, 0, 0, 16'h0000, r);
    chk(32'(r), 32'h5713);
    h.acc(1, 1, 0, 16'h3000, r);
    h.acc(1, 0, 0, 16'h0000, r);
    chk(32'(big), 32'h0);
  endtask : t_endian
  task automatic t_8bit();
    @(negedge sys_clk) w16 = 1'b0;
    h.acc(1, 1, 0, 16'h00D1, r);
    h.acc(1, 1, 0, 16'h0000, r);
    chk(32'(cmd.addr), 32'h034);
    chk(32'(cmd.lanes), 32'h2);
    h.acc(0, 0, 0, 16'h0000, r);
    chk(32'(r[7:0]), 32'h13);
    wq.delete();
    h.acc(1, 0, 0, 16'h5AA5, r);
    chk(wq[0].data, 32'hA5A5A5A5);
    h.acc(0, 1, 0, 16'h0000, r);
    chk(32'(r), 32'h0);
    @(negedge sys_clk) w16 = 1'b1;
  endtask : t_8bit
  task automatic t_irq();
    @(negedge sys_clk) irq = 1'b1;
    @(negedge sys_clk);
    chk(32'(intr_n), 32'h0);
    irq = 1'b0;
    @(negedge sys_clk);
    chk(32'(intr_n), 32'h1);
  endtask : t_irq
  task automatic t_strap();
    @(negedge sys_clk) strap = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(32'(big), 32'h1);
  endtask : t_strap
  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(32'(big), 32'h0);
    t_cmd16();
    t_data16();
    t_cs();
    t_fill();
    t_endian();
    t_8bit();
    t_irq();
    t_strap();
    final_report();
  end
endmodule : test_indirect_async_host_bus_port
`default_nettype wire
